// File: ucn_pkg.sv
// Shared constants and types for the user clock network helper block.
package ucn_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int unsigned UCN_ADDR_W = 4;   // Byte address width.
    localparam int unsigned UCN_DATA_W = 32;  // Data width.
    localparam int unsigned UCN_BE_W   = 4;   // Byte enable width.
    localparam int unsigned UCN_DIV_W  = 4;   // Divider code width.
    localparam int unsigned UCN_SYNC_N = 2;   // Release sync stages.

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_DIV    = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int unsigned CTRL_TX_RESET = 0;  // Hold transmit helper.
    localparam int unsigned CTRL_RX_RESET = 1;  // Hold receive helper.
    localparam int unsigned CTRL_TX_EXT   = 2;  // Transmit helper outside.
    localparam int unsigned CTRL_RX_EXT   = 3;  // Receive helper outside.
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0003;
    localparam logic [31:0] CTRL_MASK     = 32'h0000_000F;

    // ------------------------------------------------------------
    // Divider register fields (code 0 passes the source through)
    // ------------------------------------------------------------
    localparam int unsigned DIV_TX_FIRST  = 0;
    localparam int unsigned DIV_TX_SECOND = 4;
    localparam int unsigned DIV_RX_FIRST  = 8;
    localparam int unsigned DIV_RX_SECOND = 12;
    localparam logic [31:0] DIV_RESET     = 32'h0000_0000;
    localparam logic [31:0] DIV_MASK      = 32'h0000_FFFF;

    // ------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------
    localparam int unsigned ST_TX_ACTIVE = 0;
    localparam int unsigned ST_RX_ACTIVE = 1;
    localparam int unsigned ST_TX_HELD   = 2;
    localparam int unsigned ST_RX_HELD   = 3;
    localparam int unsigned ST_TX_DEP    = 4;
    localparam int unsigned ST_RX_DEP    = 5;

    // Bus answer state.
    typedef enum logic [0:0] {
        UCN_BUS_IDLE   = 1'b0,
        UCN_BUS_ANSWER = 1'b1
    } ucn_bus_state_t;

endpackage

// File: ucn_release_sync.sv
// Reset-release synchroniser stepped by the second user clock.
`timescale 1ns/100ps
`default_nettype none

module ucn_release_sync #(
    parameter int unsigned STAGES = 2
) (
    // Clock and reset.
    input  wire logic core_clk,
    input  wire logic reset,
    // Control.
    input  wire logic hold,
    input  wire logic step,
    // Result.
    output var  logic released
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (STAGES < 2) begin : g_bad_stages
        $error("ucn_release_sync needs at least two stages.");
    end

    logic [STAGES-1:0] stage;  // Shift chain; bit 0 is the first stage.

    // Hold clears the chain at once; each step shifts a one in.
    always_ff @(posedge core_clk) begin
        if (reset || hold) begin
            stage <= '0;
        end else if (step) begin
            stage <= {stage[STAGES-2:0], 1'b1};
        end
    end

    // The last stage is the released level.
    assign released = stage[STAGES-1];

endmodule
`default_nettype wire

// File: ucn_clock_helper.sv
// One user clock helper: derives two user clocks and an active flag.
`timescale 1ns/100ps
`default_nettype none

module ucn_clock_helper
    import ucn_pkg::*;
#(
    parameter int unsigned DIV_W = ucn_pkg::UCN_DIV_W
) (
    // Clock and reset.
    input  wire logic             core_clk,
    input  wire logic             reset,
    // Source and control.
    input  wire logic             src_clk,
    input  wire logic             hold,
    input  wire logic [DIV_W-1:0] div_first,
    input  wire logic [DIV_W-1:0] div_second,
    // Derived clocks and status.
    output var  logic             user_clk,
    output var  logic             user_clk2,
    output logic                  active
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (DIV_W < 1 || DIV_W > 8) begin : g_bad_div
        $error("ucn_clock_helper divider width out of range.");
    end

    // True on the source edge that ends a half period of code div.
    function automatic logic at_limit(input logic [DIV_W-1:0] cnt,
                                      input logic [DIV_W-1:0] div);
        at_limit = (cnt == div - 1'b1);
    endfunction

    logic             src_q;     // Source level one cycle ago.
    logic             clk2_q;    // Second user clock one cycle ago.
    logic [DIV_W-1:0] cnt1;      // Source edges in this half period.
    logic [DIV_W-1:0] cnt2;      // Same, for the second clock.
    wire              src_rise = src_clk & ~src_q;
    wire              end1     = src_rise & at_limit(cnt1, div_first);
    wire              end2     = src_rise & at_limit(cnt2, div_second);
    wire              clk2_rise = user_clk2 & ~clk2_q;

    // Code 0 copies the source; otherwise toggle every div edges.
    wire next_user_clk  = (div_first == '0) ? src_clk
                        : (user_clk ^ end1);
    wire next_user_clk2 = (div_second == '0) ? src_clk
                        : (user_clk2 ^ end2);

    // ------------------------------------------------------------
    // Dividers: held low with counters clear while in reset.
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset || hold) begin
            src_q     <= 1'b0;
            clk2_q    <= 1'b0;
            cnt1      <= '0;
            cnt2      <= '0;
            user_clk  <= 1'b0;
            user_clk2 <= 1'b0;
        end else begin
            src_q     <= src_clk;
            clk2_q    <= user_clk2;
            cnt1      <= end1 ? '0 : cnt1 + DIV_W'(src_rise);
            cnt2      <= end2 ? '0 : cnt2 + DIV_W'(src_rise);
            user_clk  <= next_user_clk;
            user_clk2 <= next_user_clk2;
        end
    end

    // Active drops with hold and rises after release is synchronised
    // over two edges of the second user clock.
    ucn_release_sync #(
        .STAGES   (UCN_SYNC_N)
    ) u_release (
        .core_clk (core_clk),
        .reset    (reset),
        .hold     (hold),
        .step     (clk2_rise),
        .released (active)
    );

endmodule
`default_nettype wire

// File: ucn_user_clock_network.sv
// Transmit and receive user clock network helpers with a register slave.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Transmit user clock from source, optionally divided.
// - Second transmit user clock from same source.
// - Transmit active rises after two second user clock edges once helper released.
// - External mode drives dependent enable from active, reset inputs.
// - Receive user clock from source, optionally divided.
// - Second receive user clock from same source.
// - Receive active rises after two second user clock edges once helper released.
module ucn_user_clock_network (
    // Clock and reset.
    input  wire logic                         core_clk,
    input  wire logic                         reset,
    // Register bus slave.
    input  wire logic [ucn_pkg::UCN_ADDR_W-1:0] avs_address,
    input  wire logic                         avs_read,
    input  wire logic                         avs_write,
    input  wire logic [ucn_pkg::UCN_DATA_W-1:0] avs_writedata,
    input  wire logic [ucn_pkg::UCN_BE_W-1:0] avs_byteenable,
    output var  logic [ucn_pkg::UCN_DATA_W-1:0] avs_readdata,
    output var  logic                         avs_waitrequest,
    // Transmit helper pins.
    input  wire logic                         tx_clk_reset_in,
    input  wire logic                         tx_source_clock_in,
    input  wire logic                         tx_clock_active_in,
    output logic                              tx_user_clock_out,
    output logic                              tx_user_clock_second_out,
    output logic                              tx_clock_active_out,
    output var  logic                         tx_dependent_enable_out,
    // Receive helper pins.
    input  wire logic                         rx_clk_reset_in,
    input  wire logic                         rx_source_clock_in,
    input  wire logic                         rx_clock_active_in,
    output logic                              rx_user_clock_out,
    output logic                              rx_user_clock_second_out,
    output logic                              rx_clock_active_out,
    output var  logic                         rx_dependent_enable_out
);

    import ucn_pkg::*;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // Merges write data into a register under byte enables and a mask.
    function automatic logic [31:0] apply_be(input logic [31:0] old,
                                             input logic [31:0] wdata,
                                             input logic [3:0]  be,
                                             input logic [31:0] mask);
        logic [31:0] merged;
        merged = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                merged[8*i +: 8] = wdata[8*i +: 8];
            end
        end
        apply_be = merged & mask;
    endfunction

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    ucn_bus_state_t bus_state;      // Bus answer state.
    ucn_bus_state_t next_bus_state; // Next bus state.
    logic [31:0]    ctrl;           // Control register.
    logic [31:0]    div;            // Divider codes.

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire sel_ctrl   = (avs_address == OFS_CTRL);
    wire sel_div    = (avs_address == OFS_DIV);
    wire sel_status = (avs_address == OFS_STATUS);
    wire request    = avs_read | avs_write;

    // A write lands at the edge where waitrequest is seen low.
    wire answering  = (bus_state == UCN_BUS_ANSWER);
    wire wr_ctrl    = answering & avs_write & sel_ctrl;
    wire wr_div     = answering & avs_write & sel_div;

    // ------------------------------------------------------------
    // Helper control
    // ------------------------------------------------------------

    // External mode keeps the in-core helper idle and outputs low.
    wire tx_ext  = ctrl[CTRL_TX_EXT];
    wire rx_ext  = ctrl[CTRL_RX_EXT];

    // Pin reset or software reset holds the clocking resources.
    wire tx_hold = tx_clk_reset_in | ctrl[CTRL_TX_RESET] | tx_ext;
    wire rx_hold = rx_clk_reset_in | ctrl[CTRL_RX_RESET] | rx_ext;

    // Dependent logic follows the in-core flag, or the exposed
    // active input qualified by the exposed reset input.
    wire next_tx_dep = tx_ext
                     ? (tx_clock_active_in & ~tx_clk_reset_in)
                     : tx_clock_active_out;
    wire next_rx_dep = rx_ext
                     ? (rx_clock_active_in & ~rx_clk_reset_in)
                     : rx_clock_active_out;

    // ------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------
    wire [31:0] status_word = {
        26'h0,
        rx_dependent_enable_out,
        tx_dependent_enable_out,
        rx_hold,
        tx_hold,
        rx_clock_active_out,
        tx_clock_active_out
    };
    wire [31:0] read_mux = sel_ctrl   ? ctrl
                         : sel_div    ? div
                         : sel_status ? status_word
                         : 32'h0000_0000;

    // Unmapped addresses read zero and ignore writes.
    assign next_bus_state = (bus_state == UCN_BUS_IDLE && request)
                          ? UCN_BUS_ANSWER : UCN_BUS_IDLE;

    // ------------------------------------------------------------
    // Bus slave: one wait cycle, then a one-cycle answer.
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            bus_state       <= UCN_BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            bus_state       <= next_bus_state;
            avs_waitrequest <= (next_bus_state != UCN_BUS_ANSWER);
            if (next_bus_state == UCN_BUS_ANSWER && avs_read) begin
                avs_readdata <= read_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // Control registers: both helpers start held in reset.
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl <= CTRL_RESET;
            div  <= DIV_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl <= apply_be(ctrl, avs_writedata, avs_byteenable,
                                 CTRL_MASK);
            end
            if (wr_div) begin
                div <= apply_be(div, avs_writedata, avs_byteenable,
                                DIV_MASK);
            end
        end
    end

    // ------------------------------------------------------------
    // Dependent enables, registered.
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_dependent_enable_out <= 1'b0;
            rx_dependent_enable_out <= 1'b0;
        end else begin
            tx_dependent_enable_out <= next_tx_dep;
            rx_dependent_enable_out <= next_rx_dep;
        end
    end

    // ------------------------------------------------------------
    // Transmit helper
    // ------------------------------------------------------------
    ucn_clock_helper #(
        .DIV_W      (UCN_DIV_W)
    ) u_tx_helper (
        .core_clk   (core_clk),
        .reset      (reset),
        .src_clk    (tx_source_clock_in),
        .hold       (tx_hold),
        .div_first  (div[DIV_TX_FIRST +: UCN_DIV_W]),
        .div_second (div[DIV_TX_SECOND +: UCN_DIV_W]),
        .user_clk   (tx_user_clock_out),
        .user_clk2  (tx_user_clock_second_out),
        .active     (tx_clock_active_out)
    );

    // ------------------------------------------------------------
    // Receive helper
    // ------------------------------------------------------------
    ucn_clock_helper #(
        .DIV_W      (UCN_DIV_W)
    ) u_rx_helper (
        .core_clk   (core_clk),
        .reset      (reset),
        .src_clk    (rx_source_clock_in),
        .hold       (rx_hold),
        .div_first  (div[DIV_RX_FIRST +: UCN_DIV_W]),
        .div_second (div[DIV_RX_SECOND +: UCN_DIV_W]),
        .user_clk   (rx_user_clock_out),
        .user_clk2  (rx_user_clock_second_out),
        .active     (rx_clock_active_out)
    );

endmodule
`default_nettype wire

// File: ucn_chk.sv
// Checker for bus answers and helper clock timing at the top ports.
`timescale 1ns/100ps
`default_nettype none
module ucn_chk (
    // Clock and reset.
    input wire logic        core_clk,
    input wire logic        reset,
    // Register bus.
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // Helper pins.
    input wire logic        tx_clk_reset_in,
    input wire logic        tx_user_clock_out,
    input wire logic        tx_user_clock_second_out,
    input wire logic        tx_clock_active_out,
    input wire logic        rx_clk_reset_in,
    input wire logic        rx_user_clock_out,
    input wire logic        rx_user_clock_second_out,
    input wire logic        rx_clock_active_out
);
    // ------------------------------------------------------------
    // Bus answer timing
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_wait_one: assert property (p_wait_one) else $error("answer longer than one cycle");
    property p_wait_cause; !avs_waitrequest |-> $past(avs_read || avs_write); endproperty
    a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
    property p_answer; $rose(avs_read || avs_write) |=> !avs_waitrequest; endproperty
    a_answer: assert property (p_answer) else $error("answer not one cycle late");
    property p_unmapped;
        avs_read && !avs_waitrequest && avs_address == 4'hC |-> avs_readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    // ------------------------------------------------------------
    // Helper hold and active timing
    // ------------------------------------------------------------
    // A reset pin seen high on two samples in a row.
    sequence s_tx_held; tx_clk_reset_in ##1 tx_clk_reset_in; endsequence
    sequence s_rx_held; rx_clk_reset_in ##1 rx_clk_reset_in; endsequence
    property p_tx_drop; tx_clk_reset_in |=> !tx_clock_active_out; endproperty
    a_tx_drop: assert property (p_tx_drop) else $error("tx active kept in hold");
    property p_rx_drop; rx_clk_reset_in |=> !rx_clock_active_out; endproperty
    a_rx_drop: assert property (p_rx_drop) else $error("rx active kept in hold");
    property p_tx_rise;
        $rose(tx_clock_active_out) |-> !$past(tx_clk_reset_in, 1) && !$past(tx_clk_reset_in, 2);
    endproperty
    a_tx_rise: assert property (p_tx_rise) else $error("tx active rose too soon");
    property p_rx_rise;
        $rose(rx_clock_active_out) |-> !$past(rx_clk_reset_in, 1) && !$past(rx_clk_reset_in, 2);
    endproperty
    a_rx_rise: assert property (p_rx_rise) else $error("rx active rose too soon");
    property p_tx_still; s_tx_held |-> !tx_user_clock_out && !tx_user_clock_second_out; endproperty
    a_tx_still: assert property (p_tx_still) else $error("tx clocks run in hold");
    property p_rx_still; s_rx_held |-> !rx_user_clock_out && !rx_user_clock_second_out; endproperty
    a_rx_still: assert property (p_rx_still) else $error("rx clocks run in hold");
endmodule

bind ucn_user_clock_network ucn_chk u_chk (
    .core_clk(core_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tx_clk_reset_in(tx_clk_reset_in), .tx_user_clock_out(tx_user_clock_out),
    .tx_user_clock_second_out(tx_user_clock_second_out),
    .tx_clock_active_out(tx_clock_active_out), .rx_clk_reset_in(rx_clk_reset_in),
    .rx_user_clock_out(rx_user_clock_out), .rx_user_clock_second_out(rx_user_clock_second_out),
    .rx_clock_active_out(rx_clock_active_out)
);
`default_nettype wire

// File: ucn_src_model.sv
// Model of a transceiver output clock feeding one helper.
`timescale 1ns/100ps
`default_nettype none
module ucn_src_model #(
    parameter int unsigned HALF   = 2,  // Half period in core cycles.
    parameter int unsigned SETTLE = 8   // Cycles of running before it is stable.
) (
    // Clock.
    input  wire logic core_clk,
    // Control and outputs.
    input  wire logic run,
    output var  logic src_clk,
    output var  logic stable
);
    int unsigned ph;   // Cycles into the current half period.
    int unsigned age;  // Cycles since the source started.
    // The clock stands low while stopped and toggles every HALF cycles when running.
    always_ff @(posedge core_clk) begin
        if (!run) begin
            src_clk <= 1'b0;
            ph      <= 0;
            age     <= 0;
            stable  <= 1'b0;
        end else begin
            ph      <= (ph == HALF - 1) ? 0 : ph + 1;
            src_clk <= (ph == HALF - 1) ? ~src_clk : src_clk;
            age     <= (age < SETTLE) ? age + 1 : age;
            stable  <= (age >= SETTLE);
        end
    end
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the user clock network helpers.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, sn) begin n_tests++; if ((sn) !== (ex)) begin num_errors++; \
    $display("Error %s expected %h seen %h", nm, ex, sn); end end
module testbench;
    import ucn_pkg::*;
    logic        core_clk = 1'b0;   // Core clock.
    logic        reset    = 1'b1;   // Synchronous reset.
    logic [3:0]  addr     = 4'h0;   // Bus address.
    logic        rd       = 1'b0;   // Bus read.
    logic        wr       = 1'b0;   // Bus write.
    logic [31:0] wdata    = 32'h0;  // Bus write data.
    logic [3:0]  be       = 4'hF;   // Bus byte lanes.
    logic [1:0]  rr       = 2'b11;  // Helper reset pins, rx and tx.
    logic [1:0]  ai       = 2'b00;  // Exposed active inputs.
    logic [1:0]  run      = 2'b00;  // Source model enables.
    wire  [1:0]  src, stb, act, dep;
    wire  [3:0]  uc;                // User clocks: rx2, rx1, tx2, tx1.
    wire  [31:0] rdata;
    wire         wreq;
    wire  [5:0]  mon = {dep, act, stb};
    int          num_errors = 0;
    int          n_tests    = 0;
    int          seed;
    logic [31:0] q, e, r;
    logic [3:0]  ps;
    int          k, i, g;
    int          n [4];

    ucn_user_clock_network u_ucn_user_clock_network (
        .core_clk(core_clk), .reset(reset), .avs_address(addr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
        .avs_waitrequest(wreq), .tx_clk_reset_in(rr[0]), .tx_source_clock_in(src[0]),
        .tx_clock_active_in(ai[0]), .tx_user_clock_out(uc[0]),
        .tx_user_clock_second_out(uc[1]), .tx_clock_active_out(act[0]),
        .tx_dependent_enable_out(dep[0]), .rx_clk_reset_in(rr[1]),
        .rx_source_clock_in(src[1]), .rx_clock_active_in(ai[1]), .rx_user_clock_out(uc[2]),
        .rx_user_clock_second_out(uc[3]), .rx_clock_active_out(act[1]),
        .rx_dependent_enable_out(dep[1])
    );
    ucn_src_model #(.HALF(2)) u_ucn_src_model_tx (
        .core_clk(core_clk), .run(run[0]), .src_clk(src[0]), .stable(stb[0]));
    ucn_src_model #(.HALF(3)) u_ucn_src_model_rx (
        .core_clk(core_clk), .run(run[1]), .src_clk(src[1]), .stable(stb[1]));

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("Comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // One bus cycle, held until waitrequest is sampled low.
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] b, output logic [31:0] qo);
        int j;
        @(posedge core_clk);
        addr <= a; rd <= !w; wr <= w; wdata <= d; be <= b;
        for (j = 0; j < 20; j++) begin
            @(posedge core_clk);
            if (wreq === 1'b0) break;
        end
        if (j == 20) begin num_errors++; report_and_stop(); end
        qo = rdata;
        rd <= 1'b0; wr <= 1'b0;
    endtask
    // Bounded wait for one monitored flag to go high.
    task automatic wait_hi(input int m);
        int j;
        for (j = 0; j < 200 && mon[m] !== 1'b1; j++) @(posedge core_clk);
        if (j == 200) begin num_errors++; report_and_stop(); end
    endtask
    // Cycles between two changes of a user clock, after two settling changes.
    task automatic measure(input int c, output int gap);
        int j, s;
        logic last;
        gap = 0;
        for (s = 0; s < 3; s++) begin
            last = uc[c];
            for (j = 0; j < 200 && uc[c] === last; j++) begin
                @(posedge core_clk);
                if (s == 2) gap++;
            end
            if (j == 200) begin num_errors++; report_and_stop(); end
        end
    endtask
    // Expected gap: N source periods of 2*HALF cycles.
    function automatic int exp_gap(input int c, input int nd);
        return 2 * ((c < 2) ? 2 : 3) * nd;
    endfunction

    initial begin
        forever #2 core_clk = ~core_clk;
    end

    initial begin
        seed = 82;
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        bus(1'b0, OFS_CTRL, 32'h0, 4'hF, q);   `CHK("ctrl", CTRL_RESET, q)
        bus(1'b0, OFS_DIV, 32'h0, 4'hF, q);    `CHK("div", DIV_RESET, q)
        bus(1'b1, 4'hC, 32'hFFFF_FFFF, 4'hF, q);
        bus(1'b0, 4'hC, 32'h0, 4'hF, q);       `CHK("unmapped", 32'h0, q)
        bus(1'b1, OFS_STATUS, 32'hFFFF_FFFF, 4'hF, q);
        bus(1'b0, OFS_STATUS, 32'h0, 4'hF, q); `CHK("status", 32'h0000_000C, q)
        $display("Test reset values done");
        r = $random(seed);
        bus(1'b1, OFS_DIV, r, 4'hF, q);
        e = r & DIV_MASK;
        r = $random(seed);
        bus(1'b1, OFS_DIV, r, 4'h1, q);
        e = {e[31:8], r[7:0]} & DIV_MASK;
        bus(1'b0, OFS_DIV, 32'h0, 4'hF, q);    `CHK("div merge", e, q)
        bus(1'b1, OFS_DIV, 32'h0, 4'hF, q);
        $display("Test byte lanes done");
        run <= 2'b11;
        wait_hi(0);
        wait_hi(1);
        rr <= 2'b00;
        bus(1'b1, OFS_CTRL, 32'h0, 4'hF, q);
        wait_hi(2);
        wait_hi(3);
        bus(1'b0, OFS_STATUS, 32'h0, 4'hF, q); `CHK("status run", 32'h33, q)
        for (i = 0; i < 24; i++) begin
            @(posedge core_clk);
            for (k = 0; k < 4; k++) if (i > 0) `CHK("follow", ps[k], uc[k])
            ps = {src[1], src[1], src[0], src[0]};
        end
        $display("Test pass-through done");
        for (k = 0; k < 4; k++) n[k] = 1 + ($unsigned($random(seed)) % 3);
        bus(1'b1, OFS_DIV, {16'h0, 4'(n[3]), 4'(n[2]), 4'(n[1]), 4'(n[0])}, 4'h3, q);
        for (k = 0; k < 4; k++) begin
            measure(k, g);
            `CHK("gap", exp_gap(k, n[k]), g)
        end
        $display("Test divide done");
        for (k = 0; k < 2; k++) begin
            @(posedge core_clk);
            rr[k] <= 1'b1;
            repeat (3) @(posedge core_clk);
            `CHK("active held", 1'b0, act[k])
            rr[k] <= 1'b0;
            wait_hi(2 + k);
        end
        $display("Test pin reset done");
        for (k = 0; k < 2; k++) begin
            ai[k] <= 1'b1;
            bus(1'b1, OFS_CTRL, 32'h4 << k, 4'hF, q);
            repeat (3) @(posedge core_clk);
            `CHK("ext active", 1'b0, act[k])
            `CHK("ext clock", 1'b0, uc[2 * k])
            `CHK("ext enable", 1'b1, dep[k])
            rr[k] <= 1'b1;
            repeat (3) @(posedge core_clk);
            `CHK("ext reset", 1'b0, dep[k])
            rr[k] <= 1'b0;
            ai[k] <= 1'b0;
            repeat (3) @(posedge core_clk);
            `CHK("ext idle", 1'b0, dep[k])
            bus(1'b1, OFS_CTRL, 32'h0, 4'hF, q);
        end
        $display("Test external mode done");
        report_and_stop();
    end
endmodule
`default_nettype wire
